/* logic/csa_status_aux.sv */
// Function
// - carry flag set on add carry or subtract borrow, else cleared by arithmetic
// - aux carry set on carry into or borrow from upper nibble, else cleared
// - user flags at bits 5 and 1, software only, bit accessible
// - bank select bits 4:3 choose bank base address, eight bytes apart
// - overflow set on signed overflow from add, add with carry, subtract
// - overflow set when multiply product exceeds 255
// - overflow set when divide has zero divisor
// - overflow cleared by those instructions when no overflow condition met
// - read-only parity bit 0 is high for odd accumulator one count
// - secondary accumulator at 0xF0, read-write, resets zero, bit addressable
// - status word at 0xD0, all pages, bit addressable, resets zero
// - unique serial value loaded in production, readable by firmware
// - four serial bytes, highest register most significant byte
// - serial bytes decoded at 0xF9 to 0xFC only on page 0x0F
// - serial bytes accept writes as general purpose storage
// - only addresses ending 0x0 or 0x8 are bit addressable
`timescale 1ns/10ps
`default_nettype none
module csa_status_aux
    import csa_pkg::*;
(
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      nrst,
    // register bus from the core
    input  wire csa_pkg::csa_sfr_req_type  sfrReq,
    output logic [7:0]                     rdData,
    output logic                           rdHit,
    // arithmetic datapath
    input  wire csa_pkg::csa_arith_type    arith,
    input  wire logic [7:0]                accumulator,
    // nonvolatile serial source
    input  wire logic [31:0]               serialIn,
    // status towards the core
    output logic [7:0]                     programStatusWord,
    output logic [7:0]                     secondaryAccumulator,
    output logic [1:0]                     bankSelect,
    output logic [7:0]                     bankBase
);
    import csa_pkg::*;

    logic [7:0]  statusQ;
    logic [7:0]  statusD;
    logic [7:0]  secondaryQ;
    logic [7:0]  secondaryD;
    logic [31:0] serialQ;
    logic [7:0]  rdDataQ;
    logic        rdHitQ;
    logic        parityBit;
    logic [7:0]  byteAddr;
    logic [2:0]  bitIdx;
    logic        bitOk;
    logic        hitStatus;
    logic        hitSecondary;
    logic        serialPage;
    logic [7:0]  readByte;
    logic        readValid;

    assign parityBit = ^accumulator;

    // bit accesses carry byte address in [7:3] and bit index in [2:0]
    assign byteAddr = sfrReq.bitMode ? {sfrReq.addr[7:3], 3'h0} : sfrReq.addr;
    assign bitIdx   = sfrReq.addr[2:0];
    assign bitOk    = (byteAddr[3:0] == BIT_ADDR_NIBBLE_A)
                   || (byteAddr[3:0] == BIT_ADDR_NIBBLE_B);

    // status word and secondary accumulator ignore the page
    assign hitStatus    = (byteAddr == ADDR_STATUS_WORD);
    assign hitSecondary = (byteAddr == ADDR_SECONDARY_ACC);
    assign serialPage   = (sfrReq.page == PAGE_SERIAL) && !sfrReq.bitMode;

    function automatic logic [7:0] merge(input logic [7:0] old, input logic isBit,
                                         input logic [2:0] idx, input logic [7:0] wd);
        logic [7:0] res;
        res = old;
        if (isBit) begin
            res[idx] = wd[0];
        end else begin
            res = wd;
        end
        return res;
    endfunction

    always_comb begin
        statusD = statusQ;
        if (sfrReq.wr && hitStatus && (bitOk || !sfrReq.bitMode)) begin
            statusD = merge(statusQ, sfrReq.bitMode, bitIdx, sfrReq.wdata);
        end
        // arithmetic result wins over a software write in the same cycle
        if (arith.valid) begin
            unique case (arith.op)
                OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW: begin
                    statusD[CARRY_POS] = arith.carry;
                    statusD[AUX_POS]   = arith.auxCarry;
                    statusD[OVF_POS]   = arith.signedOvf;
                end
                OP_MULTIPLY: begin
                    statusD[CARRY_POS] = 1'b0;
                    statusD[AUX_POS]   = 1'b0;
                    statusD[OVF_POS]   = |arith.productHigh;
                end
                OP_DIVIDE: begin
                    statusD[CARRY_POS] = 1'b0;
                    statusD[AUX_POS]   = 1'b0;
                    statusD[OVF_POS]   = arith.divisorZero;
                end
                OP_NONE: begin
                end
            endcase
        end
        statusD[PARITY_POS] = 1'b0;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            statusQ <= STATUS_RESET;
        end else begin
            statusQ <= statusD;
        end
    end

    always_comb begin
        secondaryD = secondaryQ;
        if (sfrReq.wr && hitSecondary && (bitOk || !sfrReq.bitMode)) begin
            secondaryD = merge(secondaryQ, sfrReq.bitMode, bitIdx, sfrReq.wdata);
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            secondaryQ <= SECONDARY_RESET;
        end else begin
            secondaryQ <= secondaryD;
        end
    end

    // serial bytes: reload each reset, writable afterwards
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            serialQ <= serialIn;
        end else if (sfrReq.wr && serialPage) begin
            unique case (byteAddr)
                ADDR_SERIAL_BYTE0: serialQ[7:0]   <= sfrReq.wdata;
                ADDR_SERIAL_BYTE1: serialQ[15:8]  <= sfrReq.wdata;
                ADDR_SERIAL_BYTE2: serialQ[23:16] <= sfrReq.wdata;
                ADDR_SERIAL_BYTE3: serialQ[31:24] <= sfrReq.wdata;
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        readByte  = BYTE_ZERO;
        readValid = 1'b0;
        if (hitStatus) begin
            readByte  = {statusQ[7:1], parityBit};
            readValid = 1'b1;
        end else if (hitSecondary) begin
            readByte  = secondaryQ;
            readValid = 1'b1;
        end else if (serialPage) begin
            readValid = 1'b1;
            unique case (byteAddr)
                ADDR_SERIAL_BYTE0: readByte = serialQ[7:0];
                ADDR_SERIAL_BYTE1: readByte = serialQ[15:8];
                ADDR_SERIAL_BYTE2: readByte = serialQ[23:16];
                ADDR_SERIAL_BYTE3: readByte = serialQ[31:24];
                default: readValid = 1'b0;
            endcase
        end
        if (sfrReq.bitMode) begin
            readByte  = {7'h00, readByte[bitIdx]};
            readValid = readValid && bitOk;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdDataQ <= BYTE_ZERO;
            rdHitQ  <= 1'b0;
        end else begin
            rdDataQ <= (sfrReq.rd && readValid) ? readByte : BYTE_ZERO;
            rdHitQ  <= sfrReq.rd && readValid;
        end
    end

    assign rdData               = rdDataQ;
    assign rdHit                = rdHitQ;
    assign programStatusWord    = {statusQ[7:1], parityBit};
    assign secondaryAccumulator = secondaryQ;
    assign bankSelect           = statusQ[BANK_HI_POS:BANK_LO_POS];
    assign bankBase = {3'h0, statusQ[BANK_HI_POS:BANK_LO_POS], 3'h0};

    property p_carryAdd;
        @(posedge mclk) disable iff (!nrst)
        (arith.valid && (arith.op == OP_ADD)) |=> (statusQ[CARRY_POS] == $past(arith.carry));
    endproperty
    a_carryAdd: assert property (p_carryAdd) else $error("carry flag wrong after add");

    property p_auxSub;
        @(posedge mclk) disable iff (!nrst)
        (arith.valid && (arith.op == OP_SUBTRACT_WITH_BORROW))
            |=> (statusQ[AUX_POS] == $past(arith.auxCarry));
    endproperty
    a_auxSub: assert property (p_auxSub) else $error("aux carry wrong after subtract");

    property p_userStable;
        @(posedge mclk) disable iff (!nrst)
        !(sfrReq.wr && hitStatus) |=> $stable({statusQ[USER0_POS], statusQ[USER1_POS]});
    endproperty
    a_userStable: assert property (p_userStable) else $error("user flag moved");

    property p_bankBase;
        @(posedge mclk) disable iff (!nrst)
        bankBase == ({6'h00, bankSelect} << BANK_STRIDE_LOG2);
    endproperty
    a_bankBase: assert property (p_bankBase) else $error("bank base mismatch");

    property p_ovfAdd;
        @(posedge mclk) disable iff (!nrst)
        (arith.valid && (arith.op == OP_ADD_WITH_CARRY))
            |=> (statusQ[OVF_POS] == $past(arith.signedOvf));
    endproperty
    a_ovfAdd: assert property (p_ovfAdd) else $error("overflow wrong after add");

    property p_ovfMul;
        @(posedge mclk) disable iff (!nrst)
        (arith.valid && (arith.op == OP_MULTIPLY) && (arith.productHigh != BYTE_ZERO))
            |=> statusQ[OVF_POS] && !statusQ[CARRY_POS];
    endproperty
    a_ovfMul: assert property (p_ovfMul) else $error("multiply overflow missed");

    property p_ovfDiv;
        @(posedge mclk) disable iff (!nrst)
        (arith.valid && (arith.op == OP_DIVIDE) && arith.divisorZero) |=> statusQ[OVF_POS];
    endproperty
    a_ovfDiv: assert property (p_ovfDiv) else $error("divide by zero missed");

    property p_ovfClear;
        @(posedge mclk) disable iff (!nrst)
        (arith.valid && (arith.op == OP_DIVIDE) && !arith.divisorZero) |=> !statusQ[OVF_POS];
    endproperty
    a_ovfClear: assert property (p_ovfClear) else $error("overflow not cleared");

    property p_parity;
        @(posedge mclk) disable iff (!nrst)
        programStatusWord[PARITY_POS] == ^accumulator;
    endproperty
    a_parity: assert property (p_parity) else $error("parity bit wrong");

    property p_serialRead;
        @(posedge mclk) disable iff (!nrst)
        (sfrReq.rd && !sfrReq.bitMode && (sfrReq.page == PAGE_SERIAL)
            && (sfrReq.addr == ADDR_SERIAL_BYTE3)) |=> (rdHit && (rdData == serialQ[31:24]));
    endproperty
    a_serialRead: assert property (p_serialRead) else $error("serial byte read wrong");

    property p_serialReload;
        @(posedge mclk) disable iff (!nrst)
        $rose(nrst) |-> (serialQ == $past(serialIn));
    endproperty
    a_serialReload: assert property (p_serialReload) else $error("serial not reloaded");

    property p_carryClear;
        @(posedge mclk) disable iff (!nrst)
        (arith.valid && ((arith.op == OP_MULTIPLY) || (arith.op == OP_DIVIDE)))
            |=> (!statusQ[CARRY_POS] && !statusQ[AUX_POS]);
    endproperty
    a_carryClear: assert property (p_carryClear) else $error("carry not cleared");

    property p_ovfSub;
        @(posedge mclk) disable iff (!nrst)
        (arith.valid && (arith.op == OP_SUBTRACT_WITH_BORROW))
            |=> (statusQ[OVF_POS] == $past(arith.signedOvf));
    endproperty
    a_ovfSub: assert property (p_ovfSub) else $error("subtract overflow wrong");

    property p_ovfMulClr;
        @(posedge mclk) disable iff (!nrst)
        (arith.valid && (arith.op == OP_MULTIPLY) && (arith.productHigh == BYTE_ZERO))
            |=> !statusQ[OVF_POS];
    endproperty
    a_ovfMulClr: assert property (p_ovfMulClr) else $error("mul overflow kept");

    property p_parityRead;
        @(posedge mclk) disable iff (!nrst)
        (sfrReq.rd && !sfrReq.bitMode && (sfrReq.addr == ADDR_STATUS_WORD))
            |=> (rdHit && (rdData[PARITY_POS] == ^$past(accumulator)));
    endproperty
    a_parityRead: assert property (p_parityRead) else $error("read parity wrong");

    property p_saccWrite;
        @(posedge mclk) disable iff (!nrst)
        (sfrReq.wr && !sfrReq.bitMode && (sfrReq.addr == ADDR_SECONDARY_ACC))
            |=> (secondaryQ == $past(sfrReq.wdata));
    endproperty
    a_saccWrite: assert property (p_saccWrite) else $error("sacc write lost");

    // no disable here: the check looks at the reset itself
    property p_resetVal;
        @(posedge mclk)
        !nrst |=> ((statusQ == STATUS_RESET) && (secondaryQ == SECONDARY_RESET));
    endproperty
    a_resetVal: assert property (p_resetVal) else $error("reset value wrong");

    property p_pageRefuse;
        @(posedge mclk) disable iff (!nrst)
        (sfrReq.rd && (sfrReq.page != PAGE_SERIAL)
            && (sfrReq.addr >= ADDR_SERIAL_BYTE0) && (sfrReq.addr <= ADDR_SERIAL_BYTE3))
            |=> (!rdHit && (rdData == BYTE_ZERO));
    endproperty
    a_pageRefuse: assert property (p_pageRefuse) else $error("paged read leaked");

    property p_serialWrite;
        @(posedge mclk) disable iff (!nrst)
        (sfrReq.wr && !sfrReq.bitMode && (sfrReq.page == PAGE_SERIAL)
            && (sfrReq.addr == ADDR_SERIAL_BYTE0)) |=> (serialQ[7:0] == $past(sfrReq.wdata));
    endproperty
    a_serialWrite: assert property (p_serialWrite) else $error("serial write lost");

endmodule // csa_status_aux
`default_nettype wire

/* logic/csa_pkg.sv */
`default_nettype none
package csa_pkg;

    localparam logic [7:0] ADDR_STATUS_WORD   = 8'hd0;
    localparam logic [7:0] ADDR_SECONDARY_ACC = 8'hf0;
    localparam logic [7:0] ADDR_SERIAL_BYTE0  = 8'hf9;
    localparam logic [7:0] ADDR_SERIAL_BYTE1  = 8'hfa;
    localparam logic [7:0] ADDR_SERIAL_BYTE2  = 8'hfb;
    localparam logic [7:0] ADDR_SERIAL_BYTE3  = 8'hfc;
    localparam logic [7:0] PAGE_SERIAL        = 8'h0f;

    localparam logic [3:0] BIT_ADDR_NIBBLE_A  = 4'h0;
    localparam logic [3:0] BIT_ADDR_NIBBLE_B  = 4'h8;

    localparam int CARRY_POS    = 7;
    localparam int AUX_POS      = 6;
    localparam int USER0_POS    = 5;
    localparam int BANK_HI_POS  = 4;
    localparam int BANK_LO_POS  = 3;
    localparam int OVF_POS      = 2;
    localparam int USER1_POS    = 1;
    localparam int PARITY_POS   = 0;

    localparam logic [7:0] STATUS_RESET   = 8'h00;
    localparam logic [7:0] SECONDARY_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO      = 8'h00;
    localparam int         BANK_STRIDE_LOG2 = 3;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_ADD,
        OP_ADD_WITH_CARRY,
        OP_SUBTRACT_WITH_BORROW,
        OP_MULTIPLY,
        OP_DIVIDE
    } csa_op_type;

    // one register access from the core; addr holds the bit address when bitMode is set
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       bitMode;
        logic [7:0] addr;
        logic [7:0] page;
        logic [7:0] wdata;
    } csa_sfr_req_type;

    // flag results of the arithmetic datapath for one finished instruction
    typedef struct packed {
        logic       valid;
        csa_op_type op;
        logic       carry;
        logic       auxCarry;
        logic       signedOvf;
        logic [7:0] productHigh;
        logic       divisorZero;
    } csa_arith_type;

endpackage
`default_nettype wire

/* verif/csa_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module csa_core_model (
    // clock
    input  wire logic                mclk,
    // register bus towards the block
    output var csa_pkg::csa_sfr_req_type sfrReq,
    input  wire logic [7:0]          rdData,
    input  wire logic                rdHit
);
    import csa_pkg::*;
    initial sfrReq = '0;
    // page travels with every access, driven in the same cycle as the address
    task automatic access(input logic isRd, input logic isBit, input logic [7:0] a,
                          input logic [7:0] p, input logic [7:0] w,
                          output logic [7:0] data, output logic hit);
        @(posedge mclk);
        sfrReq <= '{rd: isRd, wr: !isRd, bitMode: isBit, addr: a, page: p,
                    wdata: w};
        @(posedge mclk);
        // rd and wr drop; bitMode, addr and wdata show the inverse, page keeps its last value
        sfrReq <= '{rd: 1'b0, wr: 1'b0, bitMode: !isBit, addr: ~a, page: p, wdata: ~w};
        #1;
        data = rdData;
        hit  = rdHit;
    endtask
endmodule // csa_core_model
`default_nettype wire

/* verif/cpu_status_and_aux_registers_test.sv */
`timescale 1ns/10ps
`default_nettype none
module cpu_status_and_aux_registers_test;
    import csa_pkg::*;
    localparam logic [31:0] SERIAL_A = 32'h3c5a96e1;
    logic            mclk;
    logic            nrst;
    csa_sfr_req_type sfrReq;
    csa_arith_type   arith;
    logic [7:0]      accumulator;
    logic [31:0]     serialIn;
    logic [7:0]      rdData;
    logic            rdHit;
    logic [7:0]      program_status_word;
    logic [7:0]      sacc;
    logic [1:0]      bankSelect;
    logic [7:0]      bankBase;
    logic [7:0]      d;
    logic            h;
    int              nFail;
    int              checksDone;

    csa_status_aux uut (.mclk(mclk), .nrst(nrst), .sfrReq(sfrReq), .rdData(rdData),
        .rdHit(rdHit), .arith(arith), .accumulator(accumulator), .serialIn(serialIn),
        .programStatusWord(program_status_word), .secondaryAccumulator(sacc), .bankSelect(bankSelect),
        .bankBase(bankBase));
    csa_core_model core (.mclk(mclk), .sfrReq(sfrReq), .rdData(rdData), .rdHit(rdHit));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nFail++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic rd(input logic b, input logic [7:0] a, input logic [7:0] p);
        core.access(1'b1, b, a, p, 8'h00, d, h);
    endtask

    task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] p,
                      input logic [7:0] w);
        core.access(1'b0, b, a, p, w, d, h);
    endtask

    task automatic doArith(input csa_op_type op, input logic [2:0] cao, input logic [7:0] ph,
                           input logic dz, input logic [2:0] exp);
        @(posedge mclk);
        arith <= '{valid: 1'b1, op: op, carry: cao[2], auxCarry: cao[1], signedOvf: cao[0],
                   productHigh: ph, divisorZero: dz};
        @(posedge mclk);
        arith <= '0;
        #1;
        chk({6'h00, program_status_word[7:6], program_status_word[2]}, {6'h00, exp});
    endtask

    task automatic t_reset();
        rd(1'b0, ADDR_STATUS_WORD, PAGE_SERIAL);
        chk({h, d}, {1'b1, STATUS_RESET});
        rd(1'b0, ADDR_SECONDARY_ACC, 8'h00);
        chk({h, d}, {1'b1, SECONDARY_RESET});
        for (int i = 0; i < 4; i++) begin
            rd(1'b0, ADDR_SERIAL_BYTE0 + 8'(i), PAGE_SERIAL);
            chk({h, d}, {1'b1, SERIAL_A[8*i +: 8]});
        end
        $display("test reset values finished");
    endtask

    task automatic t_arith();
        doArith(OP_ADD, 3'b111, 8'h00, 1'b0, 3'b111);
        doArith(OP_ADD_WITH_CARRY, 3'b000, 8'hff, 1'b1, 3'b000);
        doArith(OP_SUBTRACT_WITH_BORROW, 3'b101, 8'h00, 1'b0, 3'b101);
        doArith(OP_ADD_WITH_CARRY, 3'b010, 8'h00, 1'b0, 3'b010);
        doArith(OP_ADD, 3'b111, 8'h00, 1'b0, 3'b111);
        doArith(OP_MULTIPLY, 3'b111, 8'h01, 1'b0, 3'b001);
        doArith(OP_NONE, 3'b111, 8'h00, 1'b0, 3'b001);
        doArith(OP_MULTIPLY, 3'b000, 8'h00, 1'b1, 3'b000);
        doArith(OP_DIVIDE, 3'b111, 8'h00, 1'b1, 3'b001);
        doArith(OP_DIVIDE, 3'b111, 8'hff, 1'b0, 3'b000);
        $display("test arithmetic flags finished");
    endtask

    task automatic t_user();
        wr(1'b1, 8'hd5, 8'h00, 8'h01);
        wr(1'b1, 8'hd1, 8'h0c, 8'h01);
        rd(1'b0, ADDR_STATUS_WORD, 8'h00);
        chk({h, d}, 9'h122);
        doArith(OP_ADD, 3'b111, 8'h00, 1'b0, 3'b111);
        wr(1'b1, 8'hd0, 8'h00, 8'h01);
        wr(1'b1, 8'hd5, 8'h00, 8'h00);
        chk({1'b0, program_status_word}, 9'h0c6);
        rd(1'b1, 8'hd1, 8'h00);
        chk({h, d}, 9'h101);
        wr(1'b0, ADDR_STATUS_WORD, 8'h00, 8'h00);
        $display("test user flags finished");
    endtask

    task automatic t_bank();
        for (int i = 3; i >= 0; i--) begin
            wr(1'b0, ADDR_STATUS_WORD, 8'h00, {3'b000, 2'(i), 3'b000});
            chk({1'b0, bankBase}, {4'h0, 2'(i), 3'b000});
            chk({7'h00, bankSelect}, {7'h00, 2'(i)});
        end
        $display("test bank select finished");
    endtask

    task automatic t_parity();
        for (int i = 0; i < 256; i += 17) begin
            @(posedge mclk);
            accumulator <= 8'(i);
            @(posedge mclk);
            #1;
            chk({8'h00, program_status_word[0]}, {8'h00, ^(8'(i))});
        end
        $display("test parity finished");
    endtask

    task automatic t_sacc();
        wr(1'b0, ADDR_SECONDARY_ACC, 8'h00, 8'ha5);
        wr(1'b1, 8'hf3, 8'h00, 8'h01);
        wr(1'b1, 8'hf0, 8'h0f, 8'h00);
        rd(1'b0, ADDR_SECONDARY_ACC, 8'h0c);
        chk({h, d}, 9'h1ac);
        chk({1'b0, sacc}, 9'h0ac);
        $display("test secondary accumulator finished");
    endtask

    task automatic t_serial();
        for (int i = 0; i < 4; i++) begin
            wr(1'b0, ADDR_SERIAL_BYTE0 + 8'(i), PAGE_SERIAL, 8'h11 * 8'(i + 1));
        end
        wr(1'b0, ADDR_SERIAL_BYTE1, 8'h00, 8'h99);
        wr(1'b1, ADDR_SERIAL_BYTE0, PAGE_SERIAL, 8'h01);
        for (int i = 0; i < 4; i++) begin
            rd(1'b0, ADDR_SERIAL_BYTE0 + 8'(i), PAGE_SERIAL);
            chk({h, d}, {1'b1, 8'h11 * 8'(i + 1)});
        end
        rd(1'b0, ADDR_SERIAL_BYTE0, 8'h00);
        chk({h, d}, 9'h000);
        rd(1'b0, 8'he0, 8'h00);
        chk({h, d}, 9'h000);
        rd(1'b1, ADDR_SERIAL_BYTE0, PAGE_SERIAL);
        chk({h, d}, 9'h000);
        // leave non-reset contents behind so the reset has something to clear
        wr(1'b0, ADDR_STATUS_WORD, 8'h00, 8'h22);
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(1'b0, ADDR_SERIAL_BYTE0 + 8'(i), PAGE_SERIAL);
            chk({h, d}, {1'b1, SERIAL_A[8*i +: 8]});
        end
        rd(1'b0, ADDR_SECONDARY_ACC, 8'h00);
        chk({h, d}, {1'b1, SECONDARY_RESET});
        rd(1'b0, ADDR_STATUS_WORD, 8'h00);
        chk({h, d}, {1'b1, STATUS_RESET});
        $display("test serial value finished");
    endtask

    initial begin
        #20000;
        nFail++;
        conclude();
    end

    initial begin
        nrst = 1'b0;
        arith = '0;
        accumulator = 8'h00;
        serialIn = SERIAL_A;
        nFail = 0;
        checksDone = 0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
        t_arith();
        t_user();
        t_bank();
        t_parity();
        t_sacc();
        t_serial();
        conclude();
    end
endmodule // cpu_status_and_aux_registers_test
`default_nettype wire
